// *** dlt_pkg.sv ***
// Package for the loop damping, crystal trim and bandwidth selection block
package dlt_pkg;
    // ========================================================
    // Register map, byte addressed over the device's own port
    localparam logic [7:0]  ADDR_TRIM_LO      = 8'h3c;
    localparam logic [7:0]  ADDR_TRIM_HI      = 8'h3d;
    localparam logic [7:0]  ADDR_AUTO_BW      = 8'h3b;
    localparam logic [7:0]  ADDR_LOCKED_BW    = 8'h67;
    localparam logic [7:0]  ADDR_ACQ_BW       = 8'h69;
    localparam logic [7:0]  ADDR_DAMPING      = 8'h6b;
    localparam logic [7:0]  ADDR_FIXED_BW     = 8'h6c;
    localparam logic [7:0]  ADDR_STATUS       = 8'h6d;
    // ========================================================
    // Field positions and reset values
    localparam int          AUTO_BW_BIT       = 7;
    localparam logic [15:0] TRIM_RESET        = 16'h9999;
    localparam logic [15:0] TRIM_ZERO_OFFSET  = 16'h9999;
    localparam logic [2:0]  DAMP_RESET        = 3'h3;
    localparam logic [2:0]  DAMP_CODE_MIN     = 3'h1;
    localparam logic [2:0]  DAMP_CODE_MAX     = 3'h5;
    localparam logic [3:0]  BW_RESET          = 4'h4;
    localparam logic [3:0]  ACQ_BW_RESET      = 4'h7;
    // Trim step in units of 1e-7 ppm: 0.0196229 ppm
    localparam longint      TRIM_STEP_E7PPM   = 196229;
    // ========================================================
    // Bandwidth codes, ten steps
    typedef enum logic [3:0] {
        BW_0P1, BW_0P3, BW_0P6, BW_1P2, BW_2P5, BW_4,
        BW_8, BW_18, BW_35, BW_70
    } dlt_bw_t;
    // Damping factor classes
    typedef enum logic [2:0] {
        DAMP_1P2, DAMP_2P5, DAMP_5, DAMP_10, DAMP_20
    } dlt_damp_t;
    // Loop parameters handed to the filter
    typedef struct packed {
        logic [3:0]  bandwidth;
        logic [2:0]  damping;
        logic        acquiring;
        logic [15:0] trim;
    } dlt_loop_cfg_t;
    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dlt_reg_req_t;
endpackage

// *** dlt_damp_map.sv ***
// Damping factor lookup from bandwidth and damping code
`timescale 1ns/100ps
module dlt_damp_map (
    // Selection
    input  wire logic [3:0] bw_i,
    input  wire logic [2:0] code_i,
    // Result
    output logic      [2:0] damp_o,
    output logic      [2:0] code_eff_o
);
    logic [2:0] code;
    always_comb begin
        // Undefined codes clamp to the nearest defined one
        code = code_i;
        if (code_i < dlt_pkg::DAMP_CODE_MIN) begin
            code = dlt_pkg::DAMP_CODE_MIN;
        end else if (code_i > dlt_pkg::DAMP_CODE_MAX) begin
            code = dlt_pkg::DAMP_CODE_MAX;
        end
        code_eff_o = code;
        damp_o     = 3'(dlt_pkg::DAMP_5);
        unique case (dlt_pkg::dlt_bw_t'(bw_i))
            dlt_pkg::BW_8: begin
                if (code == 3'h1) damp_o = 3'(dlt_pkg::DAMP_2P5);
            end
            dlt_pkg::BW_18, dlt_pkg::BW_35, dlt_pkg::BW_70: begin
                unique case (code)
                    3'h1: damp_o = 3'(dlt_pkg::DAMP_1P2);
                    3'h2: damp_o = 3'(dlt_pkg::DAMP_2P5);
                    3'h3: damp_o = 3'(dlt_pkg::DAMP_5);
                    3'h4: damp_o = (bw_i == 4'(dlt_pkg::BW_18)) ?
                                   3'(dlt_pkg::DAMP_5) : 3'(dlt_pkg::DAMP_10);
                    default: begin
                        if (bw_i == 4'(dlt_pkg::BW_18)) damp_o = 3'(dlt_pkg::DAMP_5);
                        else if (bw_i == 4'(dlt_pkg::BW_35)) damp_o = 3'(dlt_pkg::DAMP_10);
                        else damp_o = 3'(dlt_pkg::DAMP_20);
                    end
                endcase
            end
            default: damp_o = 3'(dlt_pkg::DAMP_5);
        endcase
    end
endmodule

// *** dlt_loop_ctrl.sv ***
// Loop parameter control: damping, crystal trim and automatic bandwidth
`timescale 1ns/100ps
module dlt_loop_ctrl (
    // Clock and reset; clock is the 25 MHz system oscillator
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_i,
    // Register port
    input  wire dlt_pkg::dlt_reg_req_t  req_i,
    output logic                [7:0]   rdata_o,
    // Lock status from the phase detectors
    input  wire logic                   phase_locked_i,
    // Loop configuration to the filter
    output dlt_pkg::dlt_loop_cfg_t      loop_cfg_o,
    // Signed output offset in units of 1e-7 ppm
    output logic signed [33:0]          freq_offset_o
);
    // ========================================================
    // Registers
    logic [15:0] trim_reg, trim_next;
    logic        auto_reg, auto_next;
    logic [3:0]  acq_bw_reg, acq_bw_next;
    logic [3:0]  lck_bw_reg, lck_bw_next;
    logic [3:0]  fix_bw_reg, fix_bw_next;
    logic [2:0]  damp_code_reg, damp_code_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        lock_reg, lock_next;
    dlt_pkg::dlt_loop_cfg_t cfg_reg, cfg_next;
    // Wide enough for both range ends: -771 ppm and +514 ppm in 1e-7 ppm units
    logic signed [33:0] off_reg, off_next;

    logic [3:0]  bw_sel;
    logic [2:0]  damp_sel;
    logic [2:0]  code_eff;
    logic signed [17:0] delta;

    always_comb begin
        trim_next      = trim_reg;
        auto_next      = auto_reg;
        acq_bw_next    = acq_bw_reg;
        lck_bw_next    = lck_bw_reg;
        fix_bw_next    = fix_bw_reg;
        damp_code_next = damp_code_reg;
        rdata_next     = rdata_reg;
        lock_next      = phase_locked_i;
        if (req_i.wr) begin
            unique case (req_i.addr)
                dlt_pkg::ADDR_TRIM_LO:   trim_next[7:0]  = req_i.wdata;
                dlt_pkg::ADDR_TRIM_HI:   trim_next[15:8] = req_i.wdata;
                dlt_pkg::ADDR_AUTO_BW:   auto_next = req_i.wdata[dlt_pkg::AUTO_BW_BIT];
                dlt_pkg::ADDR_LOCKED_BW: lck_bw_next = req_i.wdata[3:0];
                dlt_pkg::ADDR_ACQ_BW:    acq_bw_next = req_i.wdata[3:0];
                dlt_pkg::ADDR_DAMPING:   damp_code_next = req_i.wdata[2:0];
                dlt_pkg::ADDR_FIXED_BW:  fix_bw_next = req_i.wdata[3:0];
                default: ;
            endcase
        end
        if (req_i.rd) begin
            unique case (req_i.addr)
                dlt_pkg::ADDR_TRIM_LO:   rdata_next = trim_reg[7:0];
                dlt_pkg::ADDR_TRIM_HI:   rdata_next = trim_reg[15:8];
                dlt_pkg::ADDR_AUTO_BW:   rdata_next = {auto_reg, 7'h00};
                dlt_pkg::ADDR_LOCKED_BW: rdata_next = {4'h0, lck_bw_reg};
                dlt_pkg::ADDR_ACQ_BW:    rdata_next = {4'h0, acq_bw_reg};
                dlt_pkg::ADDR_DAMPING:   rdata_next = {5'h00, damp_code_reg};
                dlt_pkg::ADDR_FIXED_BW:  rdata_next = {4'h0, fix_bw_reg};
                dlt_pkg::ADDR_STATUS:    rdata_next = {cfg_reg.acquiring, code_eff,
                                                       cfg_reg.bandwidth};
                default:                 rdata_next = 8'h00;
            endcase
        end
    end

    // ========================================================
    // Bandwidth selection
    always_comb begin
        if (auto_reg) begin
            // Wide while unlocked to shorten pull-in, narrow once locked
            bw_sel = lock_reg ? lck_bw_reg : acq_bw_reg;
        end else begin
            bw_sel = fix_bw_reg;
        end
        // Codes above the top step would leave the pole undefined
        if (bw_sel > 4'(dlt_pkg::BW_70)) bw_sel = 4'(dlt_pkg::BW_70);
    end

    dlt_damp_map u_damp (
        .bw_i       (bw_sel),
        .code_i     (damp_code_reg),
        .damp_o     (damp_sel),
        .code_eff_o (code_eff)
    );

    always_comb begin
        // Whole 16-bit range is legal; 0 gives about -771 ppm, ffff +514 ppm
        delta = 18'(signed'({2'b00, trim_reg})) -
                18'(signed'({2'b00, dlt_pkg::TRIM_ZERO_OFFSET}));
        off_next = 34'(delta * 34'(dlt_pkg::TRIM_STEP_E7PPM));
        cfg_next.bandwidth = bw_sel;
        cfg_next.damping   = damp_sel;
        cfg_next.acquiring = auto_reg & ~lock_reg;
        cfg_next.trim      = trim_reg;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            trim_reg      <= dlt_pkg::TRIM_RESET;
            auto_reg      <= 1'b0;
            acq_bw_reg    <= dlt_pkg::ACQ_BW_RESET;
            lck_bw_reg    <= dlt_pkg::BW_RESET;
            fix_bw_reg    <= dlt_pkg::BW_RESET;
            damp_code_reg <= dlt_pkg::DAMP_RESET;
            rdata_reg     <= 8'h00;
            lock_reg      <= 1'b0;
            cfg_reg       <= '0;
            off_reg       <= 34'sh0;
        end else begin
            trim_reg      <= trim_next;
            auto_reg      <= auto_next;
            acq_bw_reg    <= acq_bw_next;
            lck_bw_reg    <= lck_bw_next;
            fix_bw_reg    <= fix_bw_next;
            damp_code_reg <= damp_code_next;
            rdata_reg     <= rdata_next;
            lock_reg      <= lock_next;
            cfg_reg       <= cfg_next;
            off_reg       <= off_next;
        end
    end

    assign rdata_o       = rdata_reg;
    assign loop_cfg_o    = cfg_reg;
    assign freq_offset_o = off_reg;
endmodule

// *** dlt_loop_ctrl_checker.sv ***
// Assertions on the loop control block ports
`timescale 1ns/100ps
module dlt_loop_ctrl_checker (
    // Clock and reset
    input wire logic                   ref_clk_i,
    input wire logic                   rst_i,
    // Register port
    input wire dlt_pkg::dlt_reg_req_t  req_i,
    input wire logic [7:0]             rdata_o,
    // Loop side
    input wire logic                   phase_locked_i,
    input wire dlt_pkg::dlt_loop_cfg_t loop_cfg_o,
    input wire logic signed [33:0]     freq_offset_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // ====
    // Offset is exact over the whole trim range
    a_offset_lin: assert property (
        !$past(rst_i) |-> freq_offset_o ==
        34'((longint'(loop_cfg_o.trim) - 39321) * 196229)) else $error("offset");
    a_trim_reset: assert property (
        $past(rst_i, 2) && !$past(rst_i) |-> loop_cfg_o.trim == 16'h9999
        && freq_offset_o == 32'h0) else $error("trim reset");
    a_trim_lo: assert property (
        req_i.wr && req_i.addr == 8'h3c |-> ##2
        loop_cfg_o.trim[7:0] == $past(req_i.wdata, 2)) else $error("trim low");
    a_trim_hi: assert property (
        req_i.wr && req_i.addr == 8'h3d |-> ##2
        loop_cfg_o.trim[15:8] == $past(req_i.wdata, 2)) else $error("trim high");
    a_unmapped_rd: assert property (
        req_i.rd && req_i.addr == 8'h00 |=> rdata_o == 8'h00) else $error("unmapped");
    a_rdata_hold: assert property (
        !req_i.rd |=> $stable(rdata_o)) else $error("rdata moved");
    a_low_bw_damp: assert property (
        !$past(rst_i) && loop_cfg_o.bandwidth < 4'h6 |->
        loop_cfg_o.damping == 3'h2) else $error("low bw damping");
    a_code_range: assert property (
        !$past(rst_i) |-> loop_cfg_o.bandwidth <= 4'h9
        && loop_cfg_o.damping <= 3'h4) else $error("range");
    a_acq_unlock: assert property (
        !$past(rst_i, 2) && loop_cfg_o.acquiring |->
        !$past(phase_locked_i, 2)) else $error("acquiring while locked");
    c_trim_wr: cover property (req_i.wr && req_i.addr == 8'h3d);
    c_acq: cover property (loop_cfg_o.acquiring);
    c_top_damp: cover property (loop_cfg_o.damping == 3'h4);
endmodule

// *** dlt_osc_model.sv ***
// Model of the external system oscillator
`timescale 1ns/100ps
module dlt_osc_model #(parameter realtime HALF = 20.0) (
    // Clock out
    output logic clk_o
);
    initial clk_o = 1'b0;
    // Free running: the loop clock never stops
    always #(HALF) clk_o = ~clk_o;
endmodule

// *** dlt_loop_ctrl_tb.sv ***
// Self-checking bench for the loop control block
`timescale 1ns/100ps
module dlt_loop_ctrl_tb;
    logic                   ref_clk_i;
    logic                   rst_i;
    logic                   phase_locked_i;
    logic                   rd_seen = 1'b0;
    dlt_pkg::dlt_reg_req_t  req_i;
    logic [7:0]             rdata_o;
    dlt_pkg::dlt_loop_cfg_t loop_cfg_o;
    logic signed [33:0]     freq_offset_o;
    logic [7:0]             exp_q[$];
    logic [31:0]            lfsr = 32'h0001_4585;
    logic [15:0]            v;
    int                     fails = 0;
    int                     n_compared = 0;
    dlt_osc_model osc (.clk_o(ref_clk_i));
    dlt_loop_ctrl uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i),
        .rdata_o(rdata_o), .phase_locked_i(phase_locked_i),
        .loop_cfg_o(loop_cfg_o), .freq_offset_o(freq_offset_o));
    // ====
    task automatic bad(string m);
        fails++;
        $display("CHECK FAILED t=%0t %s", $time, m);
    endtask
    task automatic chk_rd(logic [7:0] g, e);
        n_compared++;
        if (g !== e) bad("read data");
    endtask
    task automatic chk_cfg(dlt_pkg::dlt_loop_cfg_t e);
        n_compared++;
        if (loop_cfg_o !== e) bad("loop config");
    endtask
    task automatic chk_off(logic signed [33:0] e);
        n_compared++;
        if (freq_offset_o !== e) bad("offset");
    endtask
    task automatic wr(logic [7:0] a, d);
        @(negedge ref_clk_i);
        req_i = '{1'b1, 1'b0, a, d};
    endtask
    task automatic rd(logic [7:0] a, e);
        @(negedge ref_clk_i);
        req_i = '{1'b0, 1'b1, a, 8'h00};
        exp_q.push_back(e);
    endtask
    task automatic idle(int n);
        repeat (n) begin
            @(negedge ref_clk_i);
            req_i = '0;
        end
    endtask
    function automatic logic [2:0] damp(int b, int c);
        int k;
        k = (c == 0) ? 1 : (c > 5) ? 5 : c;
        if (b < 6) return 3'h2;
        if (b == 6) return (k == 1) ? 3'h1 : 3'h2;
        if (b == 7) return (k > 2) ? 3'h2 : 3'(k - 1);
        if (b == 8) return (k > 3) ? 3'h3 : 3'(k - 1);
        return 3'(k - 1);
    endfunction
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic conclude();
        if (exp_q.size() != 0) bad("notes left");
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ====
    // Read data is due one cycle after the read
    always @(posedge ref_clk_i) rd_seen <= req_i.rd & ~rst_i;
    always @(negedge ref_clk_i) begin
        if (rd_seen && exp_q.size() == 0) bad("no note");
        else if (rd_seen) chk_rd(rdata_o, exp_q.pop_front());
    end
    initial begin
        req_i = '0;
        phase_locked_i = 1'b0;
        rst_i = 1'b1;
        repeat (10) @(negedge ref_clk_i);
        rst_i = 1'b0;
        rd(8'h3c, 8'h99);
        rd(8'h3d, 8'h99);
        rd(8'h00, 8'h00);
        chk_off(34'sh0);
        wr(8'h3b, 8'h00);
        // Both range ends, then random trims
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            v = (i < 2) ? {16{i[0]}} : lfsr[15:0];
            wr(8'h3c, v[7:0]);
            wr(8'h3d, v[15:8]);
            rd(8'h3c, v[7:0]);
            rd(8'h3d, v[15:8]);
            idle(3);
            chk_cfg('{4'h4, 3'h2, 1'b0, v});
            chk_off(34'((longint'(v) - 39321) * 196229));
        end
        for (int b = 5; b < 11; b++) begin
            for (int c = 0; c < 8; c++) begin
                wr(8'h6c, 8'(b));
                wr(8'h6b, 8'(c));
                idle(3);
                chk_cfg('{(b > 9) ? 4'h9 : 4'(b), damp(b, c), 1'b0, v});
            end
        end
        wr(8'h67, 8'h02);
        wr(8'h69, 8'h08);
        wr(8'h3b, 8'h80);
        idle(3);
        chk_cfg('{4'h8, 3'h3, 1'b1, v});
        rd(8'h6d, 8'hd8);
        phase_locked_i = 1'b1;
        idle(4);
        chk_cfg('{4'h2, 3'h2, 1'b0, v});
        rd(8'h6d, 8'h52);
        rd(8'h3b, 8'h80);
        rd(8'h6b, 8'h07);
        rd(8'h69, 8'h08);
        rd(8'h67, 8'h02);
        phase_locked_i = 1'b0;
        idle(4);
        chk_cfg('{4'h8, 3'h3, 1'b1, v});
        idle(2);
        conclude();
    end
endmodule
bind dlt_loop_ctrl dlt_loop_ctrl_checker chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .req_i(req_i), .rdata_o(rdata_o), .phase_locked_i(phase_locked_i),
    .loop_cfg_o(loop_cfg_o), .freq_offset_o(freq_offset_o));
